// [hdl/fru_pkg.sv]
// Constants, timing and types for the flash reset and ultra sleep block.
// Assumes a 20 MHz system clock; all counts derive from it here.
package fru_pkg;

	// System clock period in ns
	localparam int CLK_PERIOD_NS = 50;

	// Recovery after an accepted reset, ns
	localparam int RESET_RECOVERY_NS = 28000;
	// Longest ultra sleep entry time, ns (plain default)
	localparam int ULTRA_SLEEP_ENTRY_NS = 3000;
	// Longest ultra sleep exit time, ns (plain default)
	localparam int ULTRA_SLEEP_EXIT_NS = 3000;
	// Least wake select pulse time, ns (plain default)
	localparam int WAKE_SELECT_PULSE_NS = 200;

	// Least time: round up
	localparam int RESET_CYC =
		(RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest times: round down, never below one cycle
	localparam int ENTRY_CYC = (ULTRA_SLEEP_ENTRY_NS / CLK_PERIOD_NS > 0) ?
		ULTRA_SLEEP_ENTRY_NS / CLK_PERIOD_NS : 1;
	localparam int EXIT_CYC = (ULTRA_SLEEP_EXIT_NS / CLK_PERIOD_NS > 0) ?
		ULTRA_SLEEP_EXIT_NS / CLK_PERIOD_NS : 1;
	// Least time: round up
	localparam int WAKE_CYC =
		(WAKE_SELECT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Cycle counter width and its compare points
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_CYC - 1);
	localparam logic [CNT_W-1:0] ENTRY_LAST = CNT_W'(ENTRY_CYC - 1);
	localparam logic [CNT_W-1:0] EXIT_LAST  = CNT_W'(EXIT_CYC - 1);
	localparam logic [CNT_W-1:0] WAKE_MIN   = CNT_W'(WAKE_CYC);
	localparam logic [CNT_W-1:0] CNT_MAX    = '1;

	// Opcodes handled here
	localparam logic [7:0] OP_RESET_ARM   = 8'h66;
	localparam logic [7:0] OP_RESET_FIRE  = 8'h99;
	localparam logic [7:0] OP_ULTRA_ENTER = 8'h79;

	// Last clock edge index, from zero, per opcode byte on one line and on four lines; counter stop value
	localparam logic [3:0] SPI_LAST_EDGE = 4'h7;
	localparam logic [3:0] QPI_LAST_EDGE = 4'h1;
	localparam logic [3:0] EDGE_SAT      = 4'h8;

	// Power and reset states
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_RESET_WAIT,
		ST_ENTRY,
		ST_ULTRA,
		ST_EXIT
	} fru_state_e;

endpackage

// [hdl/fru_link_rx.sv]
// Link side opcode capture, clocked by the host serial clock.
// Assumes the serial clock runs only while chip select is low.
`timescale 1ns/100ps
module fru_link_rx (
	// Link clock and resets
	input  wire logic       spi_clk,
	input  wire logic       nrst,
	input  wire logic       cs_n,
	// Link data
	input  wire logic       serial_data_in,
	input  wire logic [3:0] quad_io_in,
	// Captured opcodes with toggles, edge count in gray
	output logic [7:0]      op_spi,
	output logic            op_spi_tgl,
	output logic [7:0]      op_qpi,
	output logic            op_qpi_tgl,
	output logic [2:0]      edge_gray
);

	// Long-lived link state, cleared only by system reset
	typedef struct packed {
		logic [6:0] sh1;   // Serial shift bits
		logic [3:0] sh4;   // Upper nibble on four lines
		logic [7:0] hold1; // Captured serial opcode
		logic [7:0] hold4; // Captured quad opcode
		logic       tgl1;  // Flips per serial capture
		logic       tgl4;  // Flips per quad capture
		logic [2:0] bin;   // Edge count, binary
		logic [2:0] gray;  // Edge count, gray
	} fru_link_s;

	fru_link_s q;      // Current link state
	fru_link_s d;      // Next link state
	logic [3:0] edge_q; // Edges in this frame, cleared by chip select
	logic       frame_rst_n;

	// Binary to gray
	function automatic logic [2:0] fru_to_gray(input logic [2:0] b);
		fru_to_gray = b ^ (b >> 1);
	endfunction

	// Frame ends clear the per-frame count
	assign frame_rst_n = nrst & ~cs_n;

	// Next link state
	always_comb begin
		d = q;
		d.sh1  = {q.sh1[5:0], serial_data_in};
		d.sh4  = quad_io_in;
		d.bin  = q.bin + 3'h1;
		d.gray = fru_to_gray(q.bin + 3'h1);
		// Eighth bit on one line completes the opcode, later bits ignored
		if (edge_q == fru_pkg::SPI_LAST_EDGE) begin // [RL15] [RL8]
			d.hold1 = {q.sh1, serial_data_in};
			d.tgl1  = ~q.tgl1;
		end
		// Second nibble on four lines completes the opcode
		if (edge_q == fru_pkg::QPI_LAST_EDGE) begin // [RL15] [RL8]
			d.hold4 = {q.sh4, quad_io_in};
			d.tgl4  = ~q.tgl4;
		end
	end

	// Long-lived state register
	always_ff @(posedge spi_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Per-frame edge counter, saturates after eight edges
	always_ff @(posedge spi_clk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			edge_q <= 4'h0;
		end else if (edge_q != fru_pkg::EDGE_SAT) begin
			edge_q <= edge_q + 4'h1;
		end
	end

	// Outputs straight from flops
	assign op_spi     = q.hold1;
	assign op_spi_tgl = q.tgl1;
	assign op_qpi     = q.hold4;
	assign op_qpi_tgl = q.tgl4;
	assign edge_gray  = q.gray;

endmodule

// [hdl/fru_top.sv]
// Flash software reset and ultra sleep command control.
// Assumes host drives chip select, serial clock and data lines;
// quad mode, deep power-down and busy come from sibling logic.
//
// Behaviour
// RL1: Accepted reset aborts work, clears volatile state
// RL2: Arm and fire accepted on one or four lines
// RL3: Fire only directly after arm; else disarm
// RL4: No instruction accepted during reset recovery
// RL5: Host checks busy and suspend before reset
// RL6: Ultra sleep ignores every instruction
// RL7: Entry opcode in deep power-down, then select high
// RL8: Bits after entry opcode ignored within frame
// RL9: Partial or unaligned entry frame aborts to standby
// RL10: Power-up lands in standby, never ultra sleep
// RL11: Entry ignored while program or erase runs
// RL12: Wake pulse of least length; dummy byte ignored
// RL13: Standby within exit time after wake pulse
// RL14: Frames during exit time are ignored
// RL15: Decode only after all eight opcode bits
`timescale 1ns/100ps
module fru_top (
	// Clocks and reset
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       spi_clk,
	// Link pins
	input  wire logic       cs_n,
	input  wire logic       serial_data_in,
	input  wire logic [3:0] quad_io_in,
	// Status from sibling blocks
	input  wire logic       quad_command_mode,
	input  wire logic       deep_power_down,
	input  wire logic       op_busy,
	// Decoded instruction to sibling blocks
	output logic            cmd_valid,
	output logic [7:0]      cmd_opcode,
	// Reset results
	output logic            volatile_clear,
	output logic            recovering,
	// Power state
	output logic            standby,
	output logic            ultra_sleep
);

	// Whole control state
	typedef struct packed {
		logic [1:0]       cs_sy;     // Chip select synchroniser
		logic [1:0][2:0]  gray_sy;   // Edge count synchroniser
		logic [1:0]       tgl1_sy;   // Serial capture toggle sync
		logic [1:0]       tgl4_sy;   // Quad capture toggle sync
		logic             cs_seen;   // Last synced chip select
		logic             tgl1_seen; // Last synced serial toggle
		logic             tgl4_seen; // Last synced quad toggle
		logic [2:0]       gray_start; // Edge count at frame start
		fru_pkg::fru_state_e st;     // Power and reset state
		logic             armed;     // Reset armed
		logic             pend_entry; // Entry opcode seen this frame
		logic             frame_ign; // Frame began outside standby
		logic [fru_pkg::CNT_W-1:0] cnt; // State timer
		logic             cmd_valid; // Opcode accepted pulse
		logic [7:0]       cmd_opcode; // Last accepted opcode
		logic             volatile_clear; // Reset pulse
	} fru_ctl_s;

	fru_ctl_s   q;        // Current state
	fru_ctl_s   d;        // Next state
	logic [7:0] op_spi;   // Serial opcode from link
	logic       op_spi_tgl;
	logic [7:0] op_qpi;   // Quad opcode from link
	logic       op_qpi_tgl;
	logic [2:0] edge_gray; // Link edge count
	logic       op_evt;   // New opcode this cycle
	logic [7:0] op;       // Opcode for current mode
	logic       cs_now;   // Synced chip select
	logic       frame_rise; // Frame just ended
	logic       aligned;  // Frame ended on a byte boundary
	logic [2:0] edges;    // Edges in frame, modulo eight
	logic       entering; // Entry timer running
	logic       waking;   // Exit timer running

	// Gray to binary
	function automatic logic [2:0] fru_from_gray(input logic [2:0] g);
		fru_from_gray = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
	endfunction

	// Link side capture in the serial clock domain
	fru_link_rx u_link (
		.spi_clk        (spi_clk),
		.nrst           (nrst),
		.cs_n           (cs_n),
		.serial_data_in (serial_data_in),
		.quad_io_in     (quad_io_in),
		.op_spi         (op_spi),
		.op_spi_tgl     (op_spi_tgl),
		.op_qpi         (op_qpi),
		.op_qpi_tgl     (op_qpi_tgl),
		.edge_gray      (edge_gray)
	);

	// Next state
	always_comb begin
		d = q;
		d.cmd_valid      = 1'b0;
		d.volatile_clear = 1'b0;
		// Two flops on every crossing signal but the held opcode bytes
		d.cs_sy   = {q.cs_sy[0], cs_n};
		d.gray_sy = {q.gray_sy[0], edge_gray};
		d.tgl1_sy = {q.tgl1_sy[0], op_spi_tgl};
		d.tgl4_sy = {q.tgl4_sy[0], op_qpi_tgl};
		// Edge detection on synced values
		cs_now      = q.cs_sy[1];
		frame_rise  = ~q.cs_seen & cs_now;
		d.cs_seen   = cs_now;
		d.tgl1_seen = q.tgl1_sy[1];
		d.tgl4_seen = q.tgl4_sy[1];
		// Opcode from the lane set in use
		if (quad_command_mode) begin // [RL2]
			op_evt = q.tgl4_sy[1] ^ q.tgl4_seen;
			op     = op_qpi;
		end else begin
			op_evt = q.tgl1_sy[1] ^ q.tgl1_seen;
			op     = op_spi;
		end
		// Boundary check: eight edges per byte, two on four lines
		edges = fru_from_gray(q.gray_sy[1]) - fru_from_gray(q.gray_start);
		if (quad_command_mode) begin
			aligned = ~edges[0];
		end else begin
			aligned = (edges == 3'h0);
		end
		// Idle count remembered for the next frame
		if (cs_now) begin
			d.gray_start = q.gray_sy[1];
		end
		// Frames that start outside standby are dropped whole
		if (q.cs_seen && !cs_now) begin
			d.frame_ign = (q.st != fru_pkg::ST_STANDBY); // [RL14] [RL4]
		end
		unique case (q.st)
			// Normal decode
			fru_pkg::ST_STANDBY: begin
				if (op_evt && !q.frame_ign) begin
					d.cmd_valid  = 1'b1;
					d.cmd_opcode = op;
					// Fire counts only straight after arm
					if (q.armed && op == fru_pkg::OP_RESET_FIRE) begin // [RL3]
						d.volatile_clear = 1'b1; // [RL1]
						d.st         = fru_pkg::ST_RESET_WAIT;
						d.cnt        = '0;
						d.armed      = 1'b0;
						d.pend_entry = 1'b0;
					end else begin
						// Any other opcode re-arms or disarms
						d.armed = (op == fru_pkg::OP_RESET_ARM); // [RL3]
						// Entry only from deep power-down, never while busy
						if (op == fru_pkg::OP_ULTRA_ENTER && deep_power_down &&
							!op_busy) begin // [RL7] [RL11]
							d.pend_entry = 1'b1;
						end
					end
				end
				// Entry takes effect on select high at a byte boundary
				if (frame_rise && d.st == fru_pkg::ST_STANDBY) begin
					// Test before clearing; the pending flag is used once
					if (d.pend_entry && aligned) begin // [RL9] [RL7]
						d.st  = fru_pkg::ST_ENTRY;
						d.cnt = '0;
					end
					d.pend_entry = 1'b0;
				end
			end
			// Recovery lockout
			fru_pkg::ST_RESET_WAIT: begin
				d.armed = 1'b0;
				if (q.cnt == fru_pkg::RESET_LAST) begin // [RL4]
					d.st  = fru_pkg::ST_STANDBY;
					d.cnt = '0;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			// Going to ultra sleep
			fru_pkg::ST_ENTRY: begin
				if (q.cnt == fru_pkg::ENTRY_LAST) begin // [RL7]
					d.st  = fru_pkg::ST_ULTRA;
					d.cnt = '0;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			// Asleep: only the select low time matters
			fru_pkg::ST_ULTRA: begin
				if (frame_rise) begin
					d.cnt = '0;
					if (q.cnt >= fru_pkg::WAKE_MIN) begin // [RL12]
						d.st = fru_pkg::ST_EXIT;
					end
				end else if (cs_now) begin
					d.cnt = '0;
				end else if (q.cnt != fru_pkg::CNT_MAX) begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			// Waking up
			fru_pkg::ST_EXIT: begin
				if (q.cnt == fru_pkg::EXIT_LAST) begin // [RL13]
					d.st  = fru_pkg::ST_STANDBY;
					d.cnt = '0;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
		endcase
	end

	// State register; reset lands in standby
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q       <= '0;
			q.cs_sy <= 2'h3;
			q.cs_seen <= 1'b1;
			q.st    <= fru_pkg::ST_STANDBY; // [RL10]
		end else begin
			q <= d;
		end
	end

	// Outputs from state
	assign cmd_valid      = q.cmd_valid;
	assign cmd_opcode     = q.cmd_opcode;
	assign volatile_clear = q.volatile_clear; // [RL1]
	assign recovering     = (q.st == fru_pkg::ST_RESET_WAIT);
	assign standby        = (q.st == fru_pkg::ST_STANDBY);
	assign ultra_sleep    = (q.st == fru_pkg::ST_ULTRA); // [RL6]
	assign entering       = (q.st == fru_pkg::ST_ENTRY);
	assign waking         = (q.st == fru_pkg::ST_EXIT);

	// Checks
	localparam int RESET_I = fru_pkg::RESET_CYC;
	localparam int ENTRY_I = fru_pkg::ENTRY_CYC;
	localparam int EXIT_I  = fru_pkg::EXIT_CYC;

	// Length of the current recovery run
	logic [fru_pkg::CNT_W:0] rec_len;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rec_len <= '0;
		end else if (recovering) begin
			rec_len <= rec_len + 1'b1;
		end else begin
			rec_len <= '0;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// Reset pulse comes with the first recovery cycle and lasts one cycle
	property p_rl1;
		volatile_clear |-> recovering ##1 (recovering && !volatile_clear);
	endproperty
	a_rl1: assert property (p_rl1) else $error("reset pulse w/o recovery"); // [RL1]

	// Fire after arm in standby causes the reset
	property p_rl2;
		(standby && op_evt && !q.frame_ign && q.armed &&
		 op == fru_pkg::OP_RESET_FIRE) |=> volatile_clear;
	endproperty
	a_rl2: assert property (p_rl2) else $error("fire after arm ignored"); // [RL2]

	// Reset only when armed the cycle before
	property p_rl3;
		volatile_clear |-> $past(q.armed) && !q.armed;
	endproperty
	a_rl3: assert property (p_rl3) else $error("reset without arm"); // [RL3]

	// Recovery lasts exactly its cycle count
	property p_rl4;
		$fell(recovering) |-> rec_len == RESET_I;
	endproperty
	a_rl4: assert property (p_rl4) else $error("recovery length wrong"); // [RL4]

	// Nothing accepted from a locked or sleeping state; the fire
	// report itself shares its cycle with the first recovery cycle
	property p_rl6;
		(recovering || ultra_sleep || entering || waking) |=> !cmd_valid;
	endproperty
	a_rl6: assert property (p_rl6) else $error("opcode taken when locked"); // [RL6]

	// Entry completes within the entry time
	property p_rl7;
		$rose(entering) |-> ##[1:ENTRY_I] ultra_sleep;
	endproperty
	a_rl7: assert property (p_rl7) else $error("entry too slow"); // [RL7]

	// Entry only at an aligned frame end with a pending opcode
	property p_rl9;
		$rose(entering) |-> $past(frame_rise && aligned && q.pend_entry);
	endproperty
	a_rl9: assert property (p_rl9) else $error("entry on bad frame"); // [RL9]

	// Entry is never armed while busy
	property p_rl11;
		$rose(q.pend_entry) |-> $past(!op_busy && deep_power_down);
	endproperty
	a_rl11: assert property (p_rl11) else $error("entry armed while busy"); // [RL11]

	// Wake only from sleep after a long enough pulse
	property p_rl12;
		$rose(waking) |-> $past(ultra_sleep) &&
			$past(q.cnt) >= fru_pkg::WAKE_MIN;
	endproperty
	a_rl12: assert property (p_rl12) else $error("wake pulse too short"); // [RL12]

	// Standby within the exit time
	property p_rl13;
		$rose(waking) |-> ##[1:EXIT_I] standby;
	endproperty
	a_rl13: assert property (p_rl13) else $error("exit too slow"); // [RL13]

	// Frames begun outside standby yield nothing
	property p_rl14;
		cmd_valid |-> !$past(q.frame_ign);
	endproperty
	a_rl14: assert property (p_rl14) else $error("ignored frame decoded"); // [RL14]

	// Decode only on a completed opcode
	property p_rl15;
		cmd_valid |-> $past(op_evt);
	endproperty
	a_rl15: assert property (p_rl15) else $error("decode w/o full opcode"); // [RL15]

	// Main scenarios
	c_reset: cover property (volatile_clear);
	c_sleep: cover property ($rose(ultra_sleep));
	c_wake: cover property ($rose(waking) ##[1:EXIT_I] standby);
	c_cmd: cover property (cmd_valid && !q.armed);

endmodule

// [dv/fru_host_model.sv]
// Host flash controller model that drives the link pins of the block.
// Assumes the caller paces frames; the link clock runs only in frames.
`timescale 1ns/100ps
module fru_host_model (
	// Link pins toward the device
	output logic       cs_n,
	output logic       spi_clk,
	output logic       serial_data_in,
	output logic [3:0] quad_io_in
);
	// Half period of the 125 ns link clock
	localparam real HALF = 62.5;

	// Idle: deselected, clock parked low
	initial begin
		cs_n           = 1'b1;
		spi_clk        = 1'b0;
		serial_data_in = 1'b0;
		quad_io_in     = 4'h0;
	end

	// One frame of the given edge count; cut frames are legal here
	task automatic send_frame(input logic [7:0] op, input int edges,
		input bit quad);
		int i;
		// Phase offset keeps the link unrelated to the system clock
		#(HALF / 4);
		cs_n = 1'b0;
		#100;
		// Bits on one line MSB first, or nibbles high then low
		for (i = 0; i < edges; i++) begin
			if (quad)
				quad_io_in = (i % 2 == 0) ? op[7:4] : op[3:0];
			else
				serial_data_in = op[7 - (i % 8)];
			#HALF spi_clk = 1'b1;
			#HALF spi_clk = 1'b0;
		end
		// Raise select after the last edge; edge count set by caller
		#100 cs_n = 1'b1;
		// Released lines show the inverse of the last value
		serial_data_in = ~serial_data_in;
		quad_io_in     = ~quad_io_in;
		// Gap of more than four system cycles between frames
		#300;
	endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the reset and ultra sleep command block.
// Assumes the host model owns the link pins; the bench owns status.
`timescale 1ns/100ps
module tb_top;
	// Opcode aliases
	localparam logic [7:0] ARM  = fru_pkg::OP_RESET_ARM;
	localparam logic [7:0] FIRE = fru_pkg::OP_RESET_FIRE;
	localparam logic [7:0] ULT  = fru_pkg::OP_ULTRA_ENTER;

	// Clock, reset and sibling status
	logic        sys_clk;
	logic        nrst;
	logic        quad_command_mode;
	logic        deep_power_down;
	logic        op_busy;
	// Link pins
	logic        cs_n;
	logic        spi_clk;
	logic        serial_data_in;
	logic [3:0]  quad_io_in;
	// Design outputs
	logic        cmd_valid;
	logic [7:0]  cmd_opcode;
	logic        volatile_clear;
	logic        recovering;
	logic        standby;
	logic        ultra_sleep;
	// Checking state
	int          fail_count;
	int          cmp_count;
	int          seed;
	int          rec_len;
	int          m;
	logic        rec_q;
	logic [7:0]  rnd;
	logic [15:0] exp_q[$];

	// Device under test
	fru_top dut (
		.sys_clk(sys_clk), .nrst(nrst), .spi_clk(spi_clk), .cs_n(cs_n),
		.serial_data_in(serial_data_in), .quad_io_in(quad_io_in),
		.quad_command_mode(quad_command_mode),
		.deep_power_down(deep_power_down), .op_busy(op_busy),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.volatile_clear(volatile_clear), .recovering(recovering),
		.standby(standby), .ultra_sleep(ultra_sleep)
	);

	// Host controller at the far side of the link
	fru_host_model host (
		.cs_n(cs_n), .spi_clk(spi_clk),
		.serial_data_in(serial_data_in), .quad_io_in(quad_io_in)
	);

	// System clock, 50 ns period
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Send a frame and note its expected report
	task automatic send(input logic [7:0] code, input int edges,
		input bit expect_it, input bit vc);
		if (expect_it)
			exp_q.push_back({7'h00, vc, code});
		host.send_frame(code, edges, quad_command_mode);
	endtask

	// Bounded wait for standby (0) or ultra_sleep (1) to reach a level
	task automatic wait_for(input int which, input logic val, input int lim);
		int n;
		n = 0;
		while (((which == 0) ? standby : ultra_sleep) !== val && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	// Verdict and end of run
	task automatic end_sim();
		$display("counts: compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Monitor: each report takes the oldest note; recovery length counted
	always @(negedge sys_clk) begin
		if (cmd_valid === 1'b1) begin
			if (exp_q.size() > 0)
				check({7'h00, volatile_clear, cmd_opcode}, exp_q.pop_front());
			else
				check({7'h00, volatile_clear, cmd_opcode}, 16'h0000);
		end
		if (recovering === 1'b1) begin
			rec_len++;
		end else if (rec_q === 1'b1) begin
			check(16'(rec_len), 16'(fru_pkg::RESET_CYC));
			rec_len = 0;
		end
		rec_q = recovering;
	end

	// Watchdog
	initial begin
		#1000000;
		fail_count++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end_sim();
	end

	// Main sequence
	initial begin
		seed = 85;
		fail_count = 0;
		cmp_count = 0;
		rec_len = 0;
		rec_q = 1'b0;
		nrst = 1'b0;
		quad_command_mode = 1'b0;
		deep_power_down = 1'b0;
		op_busy = 1'b0;
		repeat (3) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (3) @(negedge sys_clk);
		// Power-up lands in standby
		check({13'h0, standby, ultra_sleep, recovering}, 16'h0004);
		check({8'h00, cmd_opcode}, 16'h0000);
		$display("test power_up done");
		// Reset pair on one line, then four lines; frame in recovery
		for (m = 0; m < 2; m++) begin
			@(negedge sys_clk);
			quad_command_mode = (m == 1);
			send(ARM, m ? 2 : 8, 1'b1, 1'b0);
			send(FIRE, m ? 2 : 8, 1'b1, 1'b1);
			send(ARM, m ? 2 : 8, 1'b0, 1'b0);
			wait_for(0, 1'b1, 700);
			check({15'h0, standby}, 16'h0001);
			$display("test reset_pair mode %0d done", m);
		end
		// Other opcode between arm and fire disarms
		@(negedge sys_clk);
		quad_command_mode = 1'b0;
		rnd = 8'($random(seed));
		if (rnd == ARM || rnd == FIRE || rnd == ULT)
			rnd = 8'h01;
		send(ARM, 8, 1'b1, 1'b0);
		send(rnd, 8, 1'b1, 1'b0);
		send(FIRE, 8, 1'b1, 1'b0);
		check({15'h0, recovering}, 16'h0000);
		$display("test disarm done");
		// Cut fire frame is discarded and leaves the arm standing
		send(ARM, 8, 1'b1, 1'b0);
		send(FIRE, 5, 1'b0, 1'b0);
		send(FIRE, 8, 1'b1, 1'b1);
		wait_for(0, 1'b1, 700);
		$display("test cut_frame done");
		// Entry refused while busy, aborted when cut off a byte boundary
		@(negedge sys_clk);
		deep_power_down = 1'b1;
		op_busy = 1'b1;
		send(ULT, 8, 1'b1, 1'b0);
		repeat (80) @(negedge sys_clk);
		check({14'h0, standby, ultra_sleep}, 16'h0002);
		op_busy = 1'b0;
		send(ULT, 12, 1'b1, 1'b0);
		repeat (80) @(negedge sys_clk);
		check({14'h0, standby, ultra_sleep}, 16'h0002);
		// Entry with a trailing byte that is ignored
		send(ULT, 16, 1'b1, 1'b0);
		wait_for(1, 1'b1, 100);
		check({14'h0, standby, ultra_sleep}, 16'h0001);
		$display("test entry done");
		// Frame in sleep is ignored and wakes; frame in exit is ignored
		send(ARM, 8, 1'b0, 1'b0);
		wait_for(1, 1'b0, 100);
		check({15'h0, ultra_sleep}, 16'h0000);
		// Late in exit, so the opcode lands after standby returns
		repeat (40) @(negedge sys_clk);
		send(ARM, 8, 1'b0, 1'b0);
		wait_for(0, 1'b1, 100);
		check({14'h0, standby, ultra_sleep}, 16'h0002);
		@(negedge sys_clk);
		deep_power_down = 1'b0;
		$display("test wake done");
		repeat (10) @(negedge sys_clk);
		check(16'(exp_q.size()), 16'h0000);
		end_sim();
	end
endmodule
